// File: verilog/lui_host_pkg.sv
// constants shared by the host access port core and its serial engine
// assumes a 25 MHz core clock and a 32-bit apb master
package lui_host_pkg;
  // control modes decoded from the mode select pins
  localparam logic [1:0] MODE_HW       = 2'h0;  // shared pins are template bits
  localparam logic [1:0] MODE_SERIAL   = 2'h1;  // serial host mode
  localparam logic [1:0] MODE_PARALLEL = 2'h2;  // parallel host mode
  // apb byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;  // control
  localparam logic [7:0] OFS_RDATA  = 8'h04;  // byte returned on host reads
  localparam logic [7:0] OFS_STATUS = 8'h08;  // last write and pin state
  localparam logic [7:0] OFS_COUNT  = 8'h0c;  // host write counter
  // field positions
  localparam int CTRL_EDGE_BIT  = 0;   // out_edge_select
  localparam int ST_ADDR_LSB    = 8;   // last address field
  localparam int ST_SERIAL_BIT  = 14;  // last write came from serial port
  localparam int ST_EVENT_BIT   = 15;  // sticky write flag, write 1 clears
  localparam int ST_TMPL_LSB    = 16;  // template select value
  localparam int ST_MODE_LSB    = 19;  // decoded control mode
  // reset values
  localparam logic       CTRL_RESET  = 1'b0;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  // serial frame: command byte then data byte
  localparam logic [4:0] SER_CMD_BITS   = 5'h08;
  localparam logic [4:0] SER_FRAME_BITS = 5'h10;
  // parallel read drive states
  typedef enum logic [2:0] {
    ST_IDLE       = 3'b001,
    ST_READ_STRB  = 3'b010,
    ST_READ_DSTRB = 3'b100
  } port_state_t;
endpackage

// File: verilog/serial_link_if.sv
// carrier between the core clock domain and the serial clock domain
// assumes every level crossing it is synchronised at the receiving end, except ev_addr, ev_data and clr
interface serial_link_if;
  logic       ev_toggle;  // flips once per completed serial write
  logic [5:0] ev_addr;    // address of the last serial write
  logic [7:0] ev_data;    // data of the last serial write
  logic [7:0] rd_data;    // byte returned on serial reads
  logic       edge_sel;   // out_edge_select level
  logic       serial_en;  // serial host mode active
  logic       clr;        // core reset, clears the event toggle
  modport engine (output ev_toggle, ev_addr, ev_data, input rd_data, edge_sel, serial_en, clr);
  modport core   (input ev_toggle, ev_addr, ev_data, output rd_data, edge_sel, serial_en, clr);
endinterface

// File: verilog/serial_engine.sv
// serial host engine, clocked by the serial clock pin
// assumes chip select high between frames; it clears the frame asynchronously
module serial_engine (
  // link pins
  input  wire logic   sclk_i,
  input  wire logic   chip_sel_n_i,
  input  wire logic   serial_data_in_i,
  output logic        serial_data_out_o,
  output logic        serial_data_out_oe_o,
  // core side
  serial_link_if.engine link
);
  logic [1:0]  en_sync;    // serial_en synchroniser
  logic [1:0]  edge_sync;  // edge select synchroniser
  logic [7:0]  rd_s1;      // read byte synchroniser, first stage
  logic [7:0]  rd_s2;      // read byte synchroniser, second stage
  logic [4:0]  bit_cnt;    // bits taken this frame
  logic [15:0] in_sh;      // input shift, lsb arrives first
  logic [7:0]  out_sh;     // output shift
  logic        out_rise;   // bit launched on the rising edge
  logic        out_fall;   // same bit relaunched on the falling edge
  logic        drive;      // output enable for the read byte
  logic [7:0]  cmd;        // command byte as it completes

  assign cmd = {serial_data_in_i, in_sh[15:9]};

  // quasi-static levels from the core; software sets them before a frame
  always_ff @(posedge sclk_i) begin
    en_sync   <= {en_sync[0], link.serial_en};
    edge_sync <= {edge_sync[0], link.edge_sel};
    rd_s1     <= link.rd_data;
    rd_s2     <= rd_s1;
  end

  // input side: sample on each rising edge, lsb first
  always_ff @(posedge sclk_i or posedge chip_sel_n_i) begin
    if (chip_sel_n_i) begin
      bit_cnt <= 5'h00;
      in_sh   <= 16'h0000;
    end else if (en_sync[1] && bit_cnt != lui_host_pkg::SER_FRAME_BITS) begin
      in_sh   <= {serial_data_in_i, in_sh[15:1]};
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  // completed write: hold the word and flip the event toggle
  // the core's reset clears the toggle so that no false event follows reset;
  // the serial clock rests while the core is in reset, so release is quiet
  always_ff @(posedge sclk_i or posedge link.clr) begin
    if (link.clr) begin
      link.ev_addr   <= 6'h00;
      link.ev_data   <= 8'h00;
      link.ev_toggle <= 1'b0;
    end else if (en_sync[1] && !chip_sel_n_i && bit_cnt == lui_host_pkg::SER_FRAME_BITS - 5'h01
        && !in_sh[1]) begin
      link.ev_addr   <= in_sh[7:2];
      link.ev_data   <= {serial_data_in_i, in_sh[15:9]};
      link.ev_toggle <= ~link.ev_toggle;
    end
  end

  // output side: read byte launched once the command byte is in
  always_ff @(posedge sclk_i or posedge chip_sel_n_i) begin
    if (chip_sel_n_i) begin
      out_sh   <= 8'h00;
      out_rise <= 1'b0;
      drive    <= 1'b0;
    end else if (en_sync[1] && bit_cnt == lui_host_pkg::SER_CMD_BITS - 5'h01 && cmd[0]) begin
      out_rise <= rd_s2[0];
      out_sh   <= {1'b0, rd_s2[7:1]};
      drive    <= 1'b1;
    end else begin
      out_rise <= out_sh[0];
      out_sh   <= {1'b0, out_sh[7:1]};
    end
  end

  // falling launch is the rising value delayed half a clock
  always_ff @(negedge sclk_i or posedge chip_sel_n_i) begin
    if (chip_sel_n_i) begin
      out_fall <= 1'b0;
    end else begin
      out_fall <= out_rise;
    end
  end

  // select the launch edge; enable only while the read byte is out
  assign serial_data_out_o    = edge_sync[1] ? out_rise : out_fall;
  assign serial_data_out_oe_o = drive;
endmodule

// File: verilog/lui_host_port.sv
// host access port of an octal line interface: serial, two parallel styles, hardware
// assumes shared pins are asynchronous to clock_i and pass two flops before use
module lui_host_port (
  // clock, reset, enable
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // mode straps
  input  wire logic [1:0]  control_mode_sel_i,
  input  wire logic        bus_style_sel_i,
  input  wire logic        mux_sel_i,
  // shared pins: clock/latch/strobe/bit2, read/dir/bit1, data/write/strobe/bit0
  input  wire logic        sclk_ale_as_i,
  input  wire logic        rd_dir_i,
  input  wire logic        sdi_wr_ds_i,
  input  wire logic        chip_sel_n_i,
  // parallel buses
  input  wire logic [5:0]  addr_i,
  input  wire logic [7:0]  data_i,
  output logic      [7:0]  data_o,
  output logic             data_oe_o,
  // serial output
  output logic             serial_data_out_o,
  output logic             serial_data_out_oe_o,
  // hardware mode template selection
  output logic      [2:0]  template_sel_o
);
  localparam int NSYNC = 22;  // synchronised pin count

  serial_link_if link ();

  // pin synchronisers
  logic [NSYNC-1:0] pin_raw;     // raw asynchronous pins
  logic [NSYNC-1:0] sync1;       // first stage, read only by sync2
  logic [NSYNC-1:0] sync2;       // second stage, usable
  logic [2:0]       strb_q;      // previous synced strobes
  // decoded pins
  logic [1:0]  mode;             // control mode
  logic        style_strb;       // separate read/write strobes selected
  logic        muxed;            // shared address/data bus
  logic        cs;               // chip select asserted
  logic        p86, p85, p84;    // synced shared pins
  logic [5:0]  s_addr;           // synced address bus
  logic [7:0]  s_data;           // synced data bus
  logic        par;              // parallel host mode
  // edges
  logic        fall86, fall84, rise84;
  // access state
  lui_host_pkg::port_state_t state;  // read drive state
  lui_host_pkg::port_state_t next_state;
  logic [5:0]  lat_addr;         // latched address
  logic        wr_ev;            // parallel write this cycle
  logic [5:0]  wr_addr;          // address of that write
  logic [2:0]  ev_tgl_q;         // serial event toggle sync plus edge
  logic        ser_ev;           // serial write arrived
  // registers
  logic        edge_sel;         // out_edge_select
  logic [7:0]  rd_byte;          // byte returned on host reads
  logic [7:0]  last_data;        // last written data
  logic [5:0]  last_addr;        // last written address
  logic        last_serial;      // last write was serial
  logic        event_flag;       // sticky write flag
  logic [15:0] wr_count;         // host write count
  // apb decode
  logic        acc;              // access phase, answer not yet given
  logic        wr_acc;           // write taking effect
  logic        mapped;           // known offset

  // decode of an apb offset, used for write and read paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  assign pin_raw = {control_mode_sel_i, bus_style_sel_i, mux_sel_i, chip_sel_n_i,
                    sclk_ale_as_i, rd_dir_i, sdi_wr_ds_i, addr_i, data_i};

  // two flops on every external pin
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
        end else if (ce_i) begin
          sync1[gi] <= pin_raw[gi];
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate

  assign {mode, style_strb, muxed} = sync2[21:18];
  assign cs     = ~sync2[17];
  assign {p86, p85, p84} = sync2[16:14];
  assign s_addr = sync2[13:8];
  assign s_data = sync2[7:0];
  assign par    = (mode == lui_host_pkg::MODE_PARALLEL);

  // previous strobe levels for edge detection
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      strb_q <= 3'h7;
    end else if (ce_i) begin
      strb_q <= {p86, p85, p84};
    end
  end

  assign fall86 = strb_q[2] & ~p86;
  assign fall84 = strb_q[0] & ~p84;
  assign rise84 = ~strb_q[0] & p84;

  // address capture per bus style
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      lat_addr <= 6'h00;
    end else if (ce_i && par) begin
      if (muxed && fall86) begin
        lat_addr <= s_data[5:0];
      end else if (!muxed && !style_strb && fall84) begin
        lat_addr <= s_addr;
      end
    end
  end

  // write strobes; nonmux strobe style uses the address bus directly
  always_comb begin
    wr_ev   = 1'b0;
    wr_addr = muxed ? lat_addr : s_addr;
    if (par && cs && rise84) begin
      if (style_strb) begin
        wr_ev = 1'b1;
      end else begin
        wr_ev   = ~p85;
        wr_addr = lat_addr;
      end
    end
  end

  // read drive state machine
  always_comb begin
    next_state = state;
    case (state)
      lui_host_pkg::ST_IDLE: begin
        if (par && cs && style_strb && !p85) begin
          next_state = lui_host_pkg::ST_READ_STRB;
        end else if (par && cs && !style_strb && p85 && fall84) begin
          next_state = lui_host_pkg::ST_READ_DSTRB;
        end
      end
      lui_host_pkg::ST_READ_STRB: begin
        if (!par || !cs || p85) begin
          next_state = lui_host_pkg::ST_IDLE;
        end
      end
      lui_host_pkg::ST_READ_DSTRB: begin
        if (!par || p84) begin
          next_state = lui_host_pkg::ST_IDLE;
        end
      end
      default: next_state = lui_host_pkg::ST_IDLE;
    endcase
  end

  // state and bus drivers
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state     <= lui_host_pkg::ST_IDLE;
      data_oe_o <= 1'b0;
      data_o    <= 8'h00;
    end else if (ce_i) begin
      state     <= next_state;
      data_oe_o <= (next_state != lui_host_pkg::ST_IDLE);
      data_o    <= rd_byte;
    end
  end

  // hardware mode: shared pins become the template value
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      template_sel_o <= 3'h0;
    end else if (ce_i && mode == lui_host_pkg::MODE_HW) begin
      template_sel_o <= {p86, p85, p84};
    end
  end

  // serial event toggle: two sync flops then an edge flop
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ev_tgl_q <= 3'h0;
    end else if (ce_i) begin
      ev_tgl_q <= {ev_tgl_q[1:0], link.ev_toggle};
    end
  end

  assign ser_ev = ev_tgl_q[2] ^ ev_tgl_q[1];

  // holds the serial event toggle cleared while the core is in reset
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      link.clr <= 1'b1;
    end else begin
      link.clr <= 1'b0;
    end
  end

  assign link.rd_data   = rd_byte;
  assign link.edge_sel  = edge_sel;
  assign link.serial_en = (mode == lui_host_pkg::MODE_SERIAL);

  serial_engine u_serial (
    .sclk_i               (sclk_ale_as_i),
    .chip_sel_n_i         (chip_sel_n_i),
    .serial_data_in_i     (sdi_wr_ds_i),
    .serial_data_out_o    (serial_data_out_o),
    .serial_data_out_oe_o (serial_data_out_oe_o),
    .link                 (link)
  );

  // apb handshake: one wait state, answer from flops
  assign acc    = psel_i & penable_i & ~pready_o;
  assign wr_acc = acc & pwrite_i;
  assign mapped = hit(paddr_i, lui_host_pkg::OFS_CTRL) | hit(paddr_i, lui_host_pkg::OFS_RDATA)
                | hit(paddr_i, lui_host_pkg::OFS_STATUS) | hit(paddr_i, lui_host_pkg::OFS_COUNT);

  // software control registers
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      edge_sel <= lui_host_pkg::CTRL_RESET;
      rd_byte  <= lui_host_pkg::RDATA_RESET;
    end else if (ce_i && wr_acc) begin
      if (hit(paddr_i, lui_host_pkg::OFS_CTRL)) begin
        edge_sel <= pwdata_i[lui_host_pkg::CTRL_EDGE_BIT];
      end
      if (hit(paddr_i, lui_host_pkg::OFS_RDATA)) begin
        rd_byte <= pwdata_i[7:0];
      end
    end
  end

  // capture of host writes; a new write wins over a software clear
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      last_data   <= 8'h00;
      last_addr   <= 6'h00;
      last_serial <= 1'b0;
      event_flag  <= 1'b0;
      wr_count    <= 16'h0000;
    end else if (ce_i) begin
      if (wr_ev) begin
        last_data   <= s_data;
        last_addr   <= wr_addr;
        last_serial <= 1'b0;
      end else if (ser_ev) begin
        last_data   <= link.ev_data;
        last_addr   <= link.ev_addr;
        last_serial <= 1'b1;
      end
      if (wr_ev || ser_ev) begin
        event_flag <= 1'b1;
        wr_count   <= wr_count + 16'h0001;
      end else if (wr_acc && hit(paddr_i, lui_host_pkg::OFS_STATUS)
                   && pwdata_i[lui_host_pkg::ST_EVENT_BIT]) begin
        event_flag <= 1'b0;
      end
    end
  end

  // apb answer
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h00000000;
    end else if (ce_i) begin
      pready_o  <= acc;
      pslverr_o <= acc & ~mapped;
      prdata_o  <= 32'h00000000;
      if (acc && !pwrite_i) begin
        if (hit(paddr_i, lui_host_pkg::OFS_CTRL)) begin
          prdata_o[lui_host_pkg::CTRL_EDGE_BIT] <= edge_sel;
        end else if (hit(paddr_i, lui_host_pkg::OFS_RDATA)) begin
          prdata_o[7:0] <= rd_byte;
        end else if (hit(paddr_i, lui_host_pkg::OFS_STATUS)) begin
          prdata_o[7:0] <= last_data;
          prdata_o[lui_host_pkg::ST_ADDR_LSB +: 6] <= last_addr;
          prdata_o[lui_host_pkg::ST_SERIAL_BIT]    <= last_serial;
          prdata_o[lui_host_pkg::ST_EVENT_BIT]     <= event_flag;
          prdata_o[lui_host_pkg::ST_TMPL_LSB +: 3] <= template_sel_o;
          prdata_o[lui_host_pkg::ST_MODE_LSB +: 2] <= mode;
        end else if (hit(paddr_i, lui_host_pkg::OFS_COUNT)) begin
          prdata_o[15:0] <= wr_count;
        end
      end
    end
  end
endmodule

// File: bench/lui_host_port_chk.sv
// assertions on the host access port, bound to its top module
// assumes one core clock domain; pins are judged as that clock samples them
module lui_host_port_chk (
  // clock and reset
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  // apb
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // straps and shared pins
  input wire logic [1:0]  control_mode_sel_i,
  input wire logic        bus_style_sel_i,
  input wire logic        sclk_ale_as_i,
  input wire logic        rd_dir_i,
  input wire logic        sdi_wr_ds_i,
  input wire logic        chip_sel_n_i,
  // device outputs
  input wire logic        data_oe_o,
  input wire logic        serial_data_out_oe_o,
  input wire logic [2:0]  template_sel_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  logic       acc;   // access phase not yet answered
  logic       bad;   // offset outside the register map
  logic       pm;    // parallel host mode
  logic       hw;    // hardware mode
  logic [2:0] pins;  // shared pins read as template bits
  assign acc  = psel_i && penable_i && !pready_o;
  assign bad  = !(paddr_i inside {8'h00, 8'h04, 8'h08, 8'h0c});
  assign pm   = control_mode_sel_i == lui_host_pkg::MODE_PARALLEL;
  assign hw   = control_mode_sel_i == lui_host_pkg::MODE_HW;
  assign pins = {sclk_ale_as_i, rd_dir_i, sdi_wr_ds_i};
  // apb answers after one wait state, for one cycle, refusing holes
  wait_state_a: assert property (acc |=> pready_o)
    else $error("access not answered after one wait state");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready held longer than one cycle");
  refuse_map_a: assert property (acc && bad |=> pslverr_o && prdata_o == 32'h0)
    else $error("unmapped offset not refused");
  // template bits follow the pins only in hardware mode
  tmpl_follow_a: assert property ((hw && $stable(pins))[*8] |-> template_sel_o == pins)
    else $error("template bits do not follow the pins");
  tmpl_hold_a: assert property ((!hw)[*8] |-> $stable(template_sel_o))
    else $error("template bits moved outside hardware mode");
  // parallel read drive starts on the strobe and stops after it
  no_drive_a: assert property ((!pm)[*8] |-> !data_oe_o)
    else $error("data bus driven outside parallel mode");
  ds_drive_a:
    assert property (pm && !bus_style_sel_i && !chip_sel_n_i && rd_dir_i && $fell(sdi_wr_ds_i)
      |-> ##[1:6] data_oe_o)
    else $error("no read drive after data strobe fall");
  rd_drive_a:
    assert property (pm && bus_style_sel_i && !chip_sel_n_i && $fell(rd_dir_i)
      |-> ##[1:6] data_oe_o)
    else $error("no read drive after read strobe fall");
  release_a:
    assert property ((pm && (bus_style_sel_i ? rd_dir_i : sdi_wr_ds_i))[*8] |-> !data_oe_o)
    else $error("data bus still driven after strobe release");
  frame_only_a:
    assert property (serial_data_out_oe_o
      |-> !chip_sel_n_i && control_mode_sel_i == lui_host_pkg::MODE_SERIAL)
    else $error("serial output driven outside a serial frame");
  cover property (acc && bad);
  cover property (pm && data_oe_o);
  cover property (serial_data_out_oe_o);
endmodule

bind lui_host_port lui_host_port_chk chk_u (
  .clock_i, .rst_n_i, .psel_i, .penable_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o,
  .control_mode_sel_i, .bus_style_sel_i, .sclk_ale_as_i, .rd_dir_i, .sdi_wr_ds_i,
  .chip_sel_n_i, .data_oe_o, .serial_data_out_oe_o, .template_sel_o
);

// File: bench/host_model.sv
// host processor model: serial frames, parallel accesses, template pins
// assumes the bench resolves the data bus and calls one task at a time
module host_model (
  // pins toward the device
  output logic       cs_n_o,
  output logic       p2_o,
  output logic       p1_o,
  output logic       p0_o,
  output logic [5:0] a_o,
  output logic [7:0] d_o,
  // device answers
  input  wire logic [7:0] bus_i,
  input  wire logic       so_i,
  input  wire logic       so_oe_i
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam realtime HALF = 62.5;  // half of the 125 ns serial clock
  localparam realtime STB  = 320;   // strobe width, eight core cycles
  // idle levels at time zero
  initial begin
    cs_n_o = 1'b1;
    {p2_o, p1_o, p0_o} = 3'h7;
    a_o = 6'h00;
    d_o = 8'h00;
  end
  // sixteen bit serial frame; clock rests low outside frames
  task automatic frame(input logic [15:0] bits, input logic rise, output logic [7:0] q);
    q = 8'h00;
    p2_o = 1'b0;
    // two pulses while deselected let the engine's level synchronisers settle
    repeat (2) begin
      #HALF p2_o = 1'b1;
      #HALF p2_o = 1'b0;
    end
    #HALF cs_n_o = 1'b0;
    for (int k = 0; k < 16; k++) begin
      p0_o = bits[k];
      #HALF;
      if (!rise && k > 7) q[k-8] = so_oe_i ? so_i : 1'bx;
      p2_o = 1'b1;
      #HALF;
      if (rise && k > 6 && k < 15) q[k-7] = so_oe_i ? so_i : 1'bx;
      p2_o = 1'b0;
    end
    #HALF cs_n_o = 1'b1;
    p0_o = ~p0_o;  // released line shows no stale value
  endtask
  // one parallel access; style high uses read and write strobes
  task automatic cycle(input logic style, input logic mux, input logic rd,
                       input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
    cs_n_o = 1'b0;
    a_o = mux ? ~a : a;
    d_o = {2'b00, a};
    p2_o = 1'b1;
    p1_o = style | rd;
    #STB;
    if (mux) p2_o = 1'b0;
    #STB;
    d_o = rd ? ~d_o : d;  // host drives the complement on reads; the device drive wins
    p1_o = style ? !rd : rd;
    #40;
    p0_o = style & rd;
    #STB;
    q = bus_i;
    p0_o = 1'b1;
    p1_o = style | rd;
    #STB;
    d_o = ~d_o;
    p2_o = 1'b1;
    cs_n_o = 1'b1;
  endtask
  // drive the shared pins as plain levels
  task automatic pins(input logic [2:0] v);
    {p2_o, p1_o, p0_o} = v;
  endtask
endmodule

// File: bench/lui_host_port_bench.sv
// self-checking bench: apb register tasks plus the host model on the pins
// assumes the design and the host model are compiled before this file
module lui_host_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock_i = 1'b0;  // core clock
  logic        rst_n_i = 1'b0;  // synchronous reset
  logic        psel_i, penable_i, pwrite_i;  // apb request
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o;
  logic        pready_o, pslverr_o;
  logic [1:0]  control_mode_sel_i;  // straps
  logic        bus_style_sel_i, mux_sel_i;
  logic        sclk_ale_as_i, rd_dir_i, sdi_wr_ds_i, chip_sel_n_i;  // host pins
  logic [5:0]  addr_i;
  logic [7:0]  data_i, data_o, hd;  // bus level, device and host drive
  logic        data_oe_o, serial_data_out_o, serial_data_out_oe_o;
  logic [2:0]  template_sel_o;
  int          err_count = 0;
  int          tests_run = 0;
  int          cnt = 0;  // host writes seen so far
  assign data_i = data_oe_o ? data_o : hd;  // device wins while it drives
  always #20 clock_i = ~clock_i;
  lui_host_port dut_u (
    .clock_i, .rst_n_i, .ce_i(1'b1), .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .control_mode_sel_i, .bus_style_sel_i, .mux_sel_i,
    .sclk_ale_as_i, .rd_dir_i, .sdi_wr_ds_i, .chip_sel_n_i, .addr_i, .data_i, .data_o,
    .data_oe_o, .serial_data_out_o, .serial_data_out_oe_o, .template_sel_o
  );
  host_model host_u (
    .cs_n_o(chip_sel_n_i), .p2_o(sclk_ale_as_i), .p1_o(rd_dir_i), .p0_o(sdi_wr_ds_i),
    .a_o(addr_i), .d_o(hd), .bus_i(data_i), .so_i(serial_data_out_o),
    .so_oe_i(serial_data_out_oe_o)
  );
  // one apb transfer; waits for ready, only the watchdog ends a hang
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    @(posedge clock_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= ad;
    pwdata_i <= wd;
    @(posedge clock_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clock_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // read a register and compare
  task automatic rdc(input logic [7:0] ad, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, ad, 32'h0, r, e);
    chk(r, exp);
  endtask
  // expected status word after a host write
  function automatic logic [31:0] st(input logic [1:0] m, input logic s,
                                     input logic [5:0] ad, input logic [7:0] dt);
    return {11'h0, m, 3'h0, 1'b1, s, ad, dt};
  endfunction
  // poll the sticky write flag, check the status, clear it, check the count
  task automatic event_check(input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    int          n;
    n = 0;
    do begin
      apb(1'b0, lui_host_pkg::OFS_STATUS, 32'h0, r, e);
      n++;
    end while (r[15] !== 1'b1 && n < 40);
    chk(r & 32'h0018ffff, exp);
    apb(1'b1, lui_host_pkg::OFS_STATUS, 32'h8000, r, e);
    cnt++;
    rdc(lui_host_pkg::OFS_COUNT, 32'(cnt));
  endtask
  // print counts and verdict, end the run
  task automatic wrap_up();
    $display("%0d checks, %0d mismatches", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // main sequence
  initial begin
    logic [31:0] r;
    logic        e;
    logic [7:0]  q;
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    control_mode_sel_i = lui_host_pkg::MODE_SERIAL;
    bus_style_sel_i = 1'b1;
    mux_sel_i = 1'b0;
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1'b1;
    // reset values, an unmapped offset, the read-back byte
    rdc(lui_host_pkg::OFS_CTRL, 32'h0);
    rdc(lui_host_pkg::OFS_RDATA, 32'h0);
    rdc(lui_host_pkg::OFS_COUNT, 32'h0);
    apb(1'b0, 8'h10, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    apb(1'b1, lui_host_pkg::OFS_RDATA, 32'h5a, r, e);
    rdc(lui_host_pkg::OFS_RDATA, 32'h5a);
    // serial write and read under both launch edges
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, lui_host_pkg::OFS_CTRL, 32'(s), r, e);
      host_u.frame({8'h96 ^ 8'(s), 1'b1, 6'h2d ^ 6'(s), 1'b0}, s[0], q);
      event_check(st(lui_host_pkg::MODE_SERIAL, 1'b1, 6'h2d ^ 6'(s), 8'h96 ^ 8'(s)));
      host_u.frame({8'h00, 1'b0, 6'h07, 1'b1}, s[0], q);
      chk({24'h0, q}, 32'h5a);
    end
    // parallel write and read in every bus style
    host_u.pins(3'h7);
    control_mode_sel_i <= lui_host_pkg::MODE_PARALLEL;
    for (int k = 0; k < 4; k++) begin
      bus_style_sel_i <= k[1];
      mux_sel_i <= k[0];
      repeat (4) @(posedge clock_i);
      host_u.cycle(k[1], k[0], 1'b0, 6'h11 + 6'(k), 8'h40 + 8'(k), q);
      event_check(st(lui_host_pkg::MODE_PARALLEL, 1'b0, 6'h11 + 6'(k), 8'h40 + 8'(k)));
      host_u.cycle(k[1], k[0], 1'b1, 6'h05, 8'h00, q);
      chk({24'h0, q}, 32'h5a);
      chk({31'h0, data_oe_o}, 32'h0);
    end
    // hardware mode: pins become template bits and write nothing
    control_mode_sel_i <= lui_host_pkg::MODE_HW;
    for (int v = 0; v < 8; v++) begin
      host_u.pins(3'(v));
      repeat (10) @(posedge clock_i);  // long enough for the template follow check
      chk({29'h0, template_sel_o}, 32'(v));
    end
    rdc(lui_host_pkg::OFS_COUNT, 32'(cnt));
    wrap_up();
  end
  // watchdog: the whole sequence needs well under 100 us
  initial begin
    #1ms;
    err_count++;
    wrap_up();
  end
endmodule
